/* rtl/event_irq_regs.svh */
`ifndef EVENT_IRQ_REGS_SVH
`define EVENT_IRQ_REGS_SVH
// ****************
// register offsets
// ****************
`define ADDR_EVENT_STATUS 8'h00
`define ADDR_EVENT_MASK 8'h01
`define ADDR_IRQ_PIN_CONFIG 8'h02
`define ADDR_FIFO_LEVEL_CONFIG 8'h06
`define ADDR_CHIP_IDENTITY 8'h08
// ****************
// field positions
// ****************
`define BIT_FLUSH 15
`define BIT_RES_STATUS 7
`define BIT_SECOND_SLOT 6
`define BIT_FIRST_SLOT 5
`define BIT_LEVEL_BLOCK 8
`define BIT_PIN_ON 2
`define BIT_DRIVE_STYLE 1
`define BIT_POLARITY 0
`define LIMIT_HI 13
`define LIMIT_LO 8
`define COUNT_HI 15
`define COUNT_LO 8
`define RES_LOW_MASK 16'h001f
// ****************
// reset values
// ****************
`define RESET_MASK 16'h00ff
`define RESET_PIN_CONFIG 16'h0000
`define RESET_LEVEL_CONFIG 16'h0000
// arbitrary identity value, not any real part
`define IDENTITY_VALUE 16'h5a01
`endif

/* rtl/event_irq_pkg.sv */
package event_irq_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [7:0] reg_addr_t;
endpackage : event_irq_pkg

/* rtl/irq_pin_driver.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// pin driver: registered output and enable
// ****************
module irq_pin_driver (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // control
   input wire logic irq_active,
   input wire logic irq_pin_output_on,
   input wire logic irq_pin_drive_style,
   input wire logic irq_pin_polarity,
   // pin
   output logic irq_pin_out,
   output logic irq_pin_oe
);
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_pin_out <= 1'b0;
         irq_pin_oe <= 1'b0;
      end else begin
         irq_pin_out <= irq_active ^ irq_pin_polarity;
         // floating pin still leaves flags live upstream
         irq_pin_oe <= irq_pin_output_on &&
            (!irq_pin_drive_style || irq_active);
      end
   end
endmodule : irq_pin_driver
`default_nettype wire

/* rtl/event_status_and_irq_pin.sv */
// Behaviour
// - status bits 15:8 report FIFO bytes available to read
// - with host access on, writing one to bit 15 flushes the FIFO
// - slot events set second flag at bit 6, first at bit 5
// - writing one clears a slot flag; writing zero leaves it
// - mask bit 8 zero enables FIFO level interrupt; resets to zero
// - slot masks at bits 6 and 5 block when one; reset to one
// - pin enable bit 2 zero floats pin; flags keep updating
// - drive style one drives pin only while asserted, else always
// - polarity bit 0 zero active high, one active low
// - level interrupt when FIFO words exceed six-bit threshold
// - level interrupt withdraws itself once words no longer exceed
`timescale 1ns/10ps
`default_nettype none
`include "event_irq_regs.svh"
module event_status_and_irq_pin #(
   parameter int COUNT_WIDTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port from the serial configuration slave
   input wire logic reg_write,
   input wire logic reg_read,
   input wire event_irq_pkg::reg_addr_t reg_addr,
   input wire event_irq_pkg::reg_word_t reg_wdata,
   output event_irq_pkg::reg_word_t reg_rdata,
   // sampling engine and FIFO
   input wire logic first_slot_event,
   input wire logic second_slot_event,
   input wire logic [COUNT_WIDTH-1:0] fifo_byte_count,
   input wire logic fifo_host_access_on,
   output logic fifo_flush,
   // interrupt pin
   output logic irq_pin_out,
   output logic irq_pin_oe
);
   // ****************
   // reset words
   // ****************
   // held as parameters so single bits can be picked from them
   localparam event_irq_pkg::reg_word_t MASK_INIT = `RESET_MASK;
   localparam event_irq_pkg::reg_word_t PIN_INIT = `RESET_PIN_CONFIG;
   localparam event_irq_pkg::reg_word_t LEVEL_INIT = `RESET_LEVEL_CONFIG;
   localparam int SLOTS = 2;

   // ****************
   // state
   // ****************
   logic first_slot_event_flag;
   logic second_slot_event_flag;
   logic [SLOTS-1:0] slot_event;
   logic [SLOTS-1:0] slot_clear;
   logic slot_flag [SLOTS];
   // bit 7 then bits 4:0 of the status word
   logic [5:0] reserved_status;
   logic first_slot_irq_block;
   logic second_slot_irq_block;
   logic fifo_level_irq_block;
   logic [7:0] mask_reserved;
   logic irq_pin_output_on;
   logic irq_pin_drive_style;
   logic irq_pin_polarity;
   logic [5:0] fifo_word_level_limit;
   logic level_event;
   logic irq_active;
   logic wr_status;
   logic wr_mask;
   logic wr_pin;
   logic wr_level;
   logic [COUNT_WIDTH-2:0] fifo_words;

   assign wr_status = reg_write && reg_addr == `ADDR_EVENT_STATUS;
   assign wr_mask = reg_write && reg_addr == `ADDR_EVENT_MASK;
   assign wr_pin = reg_write && reg_addr == `ADDR_IRQ_PIN_CONFIG;
   assign wr_level = reg_write && reg_addr == `ADDR_FIFO_LEVEL_CONFIG;
   // two bytes per word; an odd trailing byte is not a word
   assign fifo_words = fifo_byte_count[COUNT_WIDTH-1:1];

   // ****************
   // slot event flags
   // ****************
   assign slot_event = {second_slot_event, first_slot_event};
   assign slot_clear = {reg_wdata[`BIT_SECOND_SLOT],
      reg_wdata[`BIT_FIRST_SLOT]};
   // a new event in the clearing cycle wins over the clear,
   // so a sample landing during service is never lost
   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge clock) begin
         if (reset) begin
            slot_flag[s] <= 1'b0;
         end else if (slot_event[s]) begin
            slot_flag[s] <= 1'b1;
         end else if (wr_status && slot_clear[s]) begin
            slot_flag[s] <= 1'b0;
         end
      end
   end
   assign first_slot_event_flag = slot_flag[0];
   assign second_slot_event_flag = slot_flag[1];

   // reserved status bits are never set here; writing ones clears them
   always_ff @(posedge clock) begin
      if (reset) begin
         reserved_status <= 6'h00;
      end else if (wr_status) begin
         reserved_status <= reserved_status & ~{reg_wdata[`BIT_RES_STATUS],
            5'(reg_wdata & `RES_LOW_MASK)};
      end
   end

   // ****************
   // flush
   // ****************
   // without host access the flush request is dropped, not queued
   always_ff @(posedge clock) begin
      if (reset) begin
         fifo_flush <= 1'b0;
      end else begin
         fifo_flush <= wr_status && fifo_host_access_on &&
            reg_wdata[`BIT_FLUSH];
      end
   end

   // ****************
   // mask and configuration
   // ****************
   always_ff @(posedge clock) begin
      if (reset) begin
         fifo_level_irq_block <= MASK_INIT[`BIT_LEVEL_BLOCK];
         second_slot_irq_block <= MASK_INIT[`BIT_SECOND_SLOT];
         first_slot_irq_block <= MASK_INIT[`BIT_FIRST_SLOT];
         mask_reserved <= MASK_INIT[7:0];
      end else if (wr_mask) begin
         fifo_level_irq_block <= reg_wdata[`BIT_LEVEL_BLOCK];
         second_slot_irq_block <= reg_wdata[`BIT_SECOND_SLOT];
         first_slot_irq_block <= reg_wdata[`BIT_FIRST_SLOT];
         mask_reserved <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_pin_output_on <= PIN_INIT[`BIT_PIN_ON];
         irq_pin_drive_style <= PIN_INIT[`BIT_DRIVE_STYLE];
         irq_pin_polarity <= PIN_INIT[`BIT_POLARITY];
      end else if (wr_pin) begin
         irq_pin_output_on <= reg_wdata[`BIT_PIN_ON];
         irq_pin_drive_style <= reg_wdata[`BIT_DRIVE_STYLE];
         irq_pin_polarity <= reg_wdata[`BIT_POLARITY];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         fifo_word_level_limit <= LEVEL_INIT[`LIMIT_HI:`LIMIT_LO];
      end else if (wr_level) begin
         fifo_word_level_limit <= reg_wdata[`LIMIT_HI:`LIMIT_LO];
      end
   end

   // ****************
   // interrupt combine
   // ****************
   // level source is not sticky, so it drops with the FIFO
   // both sides widened so the compare stays unsigned
   always_comb begin
      level_event = COUNT_WIDTH'(fifo_words) >
         COUNT_WIDTH'(fifo_word_level_limit);
      irq_active = (level_event && !fifo_level_irq_block) ||
         (first_slot_event_flag && !first_slot_irq_block) ||
         (second_slot_event_flag && !second_slot_irq_block);
   end

   irq_pin_driver pin_driver (
      .clock(clock),
      .reset(reset),
      .irq_active(irq_active),
      .irq_pin_output_on(irq_pin_output_on),
      .irq_pin_drive_style(irq_pin_drive_style),
      .irq_pin_polarity(irq_pin_polarity),
      .irq_pin_out(irq_pin_out),
      .irq_pin_oe(irq_pin_oe)
   );

   // ****************
   // read back
   // ****************
   // one cycle latency; unmapped addresses read zero
   // reserved mask bits only echo their reset ones or what the host last wrote
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         case (reg_addr)
            `ADDR_EVENT_STATUS: begin
               reg_rdata <= {8'(fifo_byte_count),
                  reserved_status[5], second_slot_event_flag,
                  first_slot_event_flag, reserved_status[4:0]};
            end
            `ADDR_EVENT_MASK: begin
               reg_rdata <= {7'h00, fifo_level_irq_block, mask_reserved[7],
                  second_slot_irq_block, first_slot_irq_block,
                  mask_reserved[4:0]};
            end
            `ADDR_IRQ_PIN_CONFIG: begin
               reg_rdata <= {13'h0000, irq_pin_output_on,
                  irq_pin_drive_style, irq_pin_polarity};
            end
            `ADDR_FIFO_LEVEL_CONFIG: begin
               reg_rdata <= {2'h0, fifo_word_level_limit, 8'h00};
            end
            `ADDR_CHIP_IDENTITY: begin
               reg_rdata <= `IDENTITY_VALUE;
            end
            default: begin
               reg_rdata <= 16'h0000;
            end
         endcase
      end
   end
endmodule : event_status_and_irq_pin
`default_nettype wire

/* bench/irq_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// host side of the pin
// ****************
module irq_host_model (
   // pin from the device
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe,
   // resistor level, high for an active low pin
   input wire logic pull_up,
   // level the host sees
   output logic irq_line
);
   // a released pin goes to the resistor, never keeps the last value
   assign irq_line = irq_pin_oe ? irq_pin_out : pull_up;
endmodule : irq_host_model
`default_nettype wire

/* bench/event_irq_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// port checker
// ****************
module event_irq_asserts #(
   parameter int COUNT_WIDTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire event_irq_pkg::reg_addr_t reg_addr,
   input wire event_irq_pkg::reg_word_t reg_wdata,
   input wire event_irq_pkg::reg_word_t reg_rdata,
   // sampling engine and FIFO
   input wire logic first_slot_event,
   input wire logic [COUNT_WIDTH-1:0] fifo_byte_count,
   input wire logic fifo_host_access_on,
   input wire logic fifo_flush,
   // interrupt pin
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe
);
   logic [2:0] cfg, m;
   logic [5:0] lim;
   logic lvl_q, pol_q;
   // shadows of config writes, since the ports alone hide the setup
   always_ff @(posedge clock) begin
      lvl_q <= (fifo_byte_count >> 1) > lim;
      pol_q <= cfg[0];
      if (reset) begin
         cfg <= 3'h0;
         m <= 3'h3;
         lim <= 6'h00;
      end else if (reg_write) begin
         if (reg_addr == 8'h02) cfg <= reg_wdata[2:0];
         if (reg_addr == 8'h01) m <= {reg_wdata[8], reg_wdata[6:5]};
         if (reg_addr == 8'h06) lim <= reg_wdata[13:8];
      end
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   flush_on_write_a: assert property (reg_write && reg_addr == 8'h00
      && reg_wdata[15] && fifo_host_access_on |=> fifo_flush)
      else $error("no flush");
   count_read_a: assert property (reg_read && reg_addr == 8'h00
      |=> reg_rdata[15:8] == $past(fifo_byte_count)) else $error("bad count");
   spare_bits_a: assert property (reg_read && reg_addr == 8'h00
      |=> reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00)
      else $error("spare bit set");
   pin_float_a: assert property (!cfg[2] |=> !irq_pin_oe)
      else $error("pin driven");
   pin_push_a: assert property (cfg[2:1] == 2'h2 |=> irq_pin_oe)
      else $error("pin undriven");
   pin_polarity_a: assert property (cfg[2:1] == 2'h3 ##1 irq_pin_oe
      |-> irq_pin_out != pol_q) else $error("wrong polarity");
   slot_raise_a: assert property (first_slot_event && !m[0]
      && cfg == 3'h4 |=> ##1 irq_pin_out) else $error("no slot irq");
   level_track_a: assert property (cfg == 3'h4 && m == 3'h3
      |=> irq_pin_out == lvl_q) else $error("bad level irq");
   level_block_a: assert property (cfg == 3'h4 && m == 3'h7
      |=> !irq_pin_out) else $error("level not blocked");
endmodule : event_irq_asserts
bind event_status_and_irq_pin event_irq_asserts #(.COUNT_WIDTH(COUNT_WIDTH))
   u_chk (.clock(clock), .reset(reset), .reg_write(reg_write),
   .reg_read(reg_read), .first_slot_event(first_slot_event),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .fifo_byte_count(fifo_byte_count), .fifo_flush(fifo_flush),
   .fifo_host_access_on(fifo_host_access_on), .irq_pin_out(irq_pin_out),
   .irq_pin_oe(irq_pin_oe));
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "event_irq_regs.svh"
// ****************
// bench
// ****************
module tb_top;
   logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic first_ev = 1'b0, second_ev = 1'b0, access_on = 1'b0;
   logic pull_up = 1'b0, flush, pin_out, pin_oe, line;
   logic [7:0] bytes = 8'h00, b;
   logic [5:0] lim;
   logic [31:0] seed = 32'h0000f5ef;
   event_irq_pkg::reg_addr_t addr = 8'h00;
   event_irq_pkg::reg_word_t wdata = 16'h0000, rdata;
   int fails = 0, checks = 0, cycles = 0;
   initial forever #2 clock = ~clock;
   event_status_and_irq_pin u_dut (.clock(clock), .reset(reset),
      .reg_write(reg_write), .reg_read(reg_read), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .first_slot_event(first_ev),
      .second_slot_event(second_ev), .fifo_byte_count(bytes),
      .fifo_host_access_on(access_on), .fifo_flush(flush),
      .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));
   irq_host_model u_host (.irq_pin_out(pin_out), .irq_pin_oe(pin_oe),
      .pull_up(pull_up), .irq_line(line));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // bytes halved to words before the compare
   function automatic logic level(input logic [7:0] c, input logic [5:0] t);
      return {1'b0, c[7:1]} > {2'h0, t};
   endfunction : level
   task automatic ck(input string n, input logic [15:0] e, s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : ck
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      ck("rdata", e, rdata);
   endtask : rd
   task automatic pulse(input logic [1:0] e);
      @(posedge clock);
      {second_ev, first_ev} <= e;
      @(posedge clock);
      {second_ev, first_ev} <= 2'h0;
   endtask : pulse
   task automatic conclude;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         conclude;
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      rd(8'h01, `RESET_MASK);
      rd(8'h08, `IDENTITY_VALUE);
      rd(8'h03, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         b = (i == 0) ? 8'hff : seed[7:0];
         @(posedge clock);
         bytes <= b;
         rd(8'h00, {b, 8'h00});
      end
      wr(8'h02, 16'h0004);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         lim = (i == 0) ? 6'h3f : seed[5:0];
         b = {1'b0, lim, 1'b0} + {5'h00, seed[10:8]} - 8'h03;
         wr(8'h06, {2'h0, lim, 8'h00});
         @(posedge clock);
         bytes <= b;
         repeat (2) @(posedge clock);
         @(negedge clock);
         ck("level pin", {15'h0000, level(b, lim)},
            {15'h0000, line});
      end
      // level source blocked by its own mask bit
      @(posedge clock);
      bytes <= 8'hff;
      wr(8'h01, 16'h01ff);
      rd(8'h01, 16'h01ff);
      @(negedge clock);
      ck("level blocked", 16'h0000, {15'h0000, line});
      wr(8'h01, `RESET_MASK);
      @(posedge clock);
      bytes <= 8'h00;
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         access_on <= i[0];
         wr(8'h00, 16'h8000);
         @(negedge clock);
         ck("flush", {15'h0000, i[0]}, {15'h0000, flush});
      end
      wr(8'h01, 16'h00df);
      pulse(2'h3);
      rd(8'h00, 16'h0060);
      wr(8'h00, 16'h009f);
      rd(8'h00, 16'h0060);
      wr(8'h00, 16'h0040);
      rd(8'h00, 16'h0020);
      // second slot alone, with the pending first slot blocked
      wr(8'h01, 16'h00bf);
      repeat (2) @(posedge clock);
      @(negedge clock);
      ck("blocked slot", 16'h0000, {15'h0000, line});
      pulse(2'h2);
      repeat (2) @(posedge clock);
      @(negedge clock);
      ck("second slot", 16'h0001, {15'h0000, line});
      wr(8'h00, 16'h0040);
      wr(8'h01, 16'h00df);
      pulse(2'h1);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) wr(8'h00, 16'h0020);
         for (int c = 0; c < 8; c++) begin
            @(posedge clock);
            pull_up <= c[0];
            wr(8'h02, c[15:0]);
            repeat (2) @(posedge clock);
            @(negedge clock);
            ck("oe", {15'h0000, c[2] & (~c[1] | p == 0)},
               {15'h0000, pin_oe});
            ck("line", {15'h0000, (c[2] & p == 0) ^ c[0]},
               {15'h0000, line});
         end
      end
      conclude;
   end
endmodule : tb_top
`default_nettype wire
